// File: design/sdwc_cfg.svh
// Constants and timing counts for the debug watchdog control block
`ifndef SDWC_CFG_SVH
`define SDWC_CFG_SVH
`define SDWC_CLK_HZ 100000000
`define SDWC_NREQ_MS 350
`define SDWC_NREQ_CYC ((`SDWC_CLK_HZ / 1000) * `SDWC_NREQ_MS)
`define SDWC_RST_MS 15
`define SDWC_RST_CYC ((`SDWC_CLK_HZ / 1000) * `SDWC_RST_MS)
`define SDWC_WD_MS 1000
`define SDWC_WD_CYC ((`SDWC_CLK_HZ / 1000) * `SDWC_WD_MS)
`define SDWC_CMD_ARM 8'h10
`define SDWC_CMD_MASK 8'hf7
`define SDWC_CMD_NDBG 8'h15
`define SDWC_MCR_HI 4'h1
`define SDWC_DATA_EXIT 4'h0
`define SDWC_MODE_NORMAL 4'h4
`define SDWC_MODE_STANDBY 4'h6
`define SDWC_MODE_STOP 4'h2
`define SDWC_MODE_SLEEP 4'h3
`endif

// File: design/sdwc_pkg.sv
// Types for the debug watchdog control block
package sdwc_pkg;
	typedef enum logic [6:0] {
		SDWC_RESET = 7'h01,
		SDWC_NREQ = 7'h02,
		SDWC_NORMAL = 7'h04,
		SDWC_STANDBY = 7'h08,
		SDWC_STOP = 7'h10,
		SDWC_SLEEP = 7'h20,
		SDWC_DEBUG = 7'h40
	} sdwc_state_t;
endpackage

// File: design/sdwc_top.sv
// Mode sequencer, debug entry and watchdog supervision of the basis chip
`timescale 1ns/1ns
`include "sdwc_cfg.svh"
module sdwc_top #(
	parameter int unsigned NREQ_CYC = `SDWC_NREQ_CYC,
	parameter int unsigned RST_CYC = `SDWC_RST_CYC,
	parameter int unsigned WD_CYC = `SDWC_WD_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic spi_wr_stb,
	input wire logic [7:0] spi_wr_byte,
	input wire logic wd_clear_stb,
	input wire logic window_mode,
	input wire logic stop_watchdog_enable,
	input wire logic main_regulator_low,
	input wire logic wake_event,
	input wire logic batfail_clear_stb,
	output logic rst_out_n,
	output logic watchdog_fault_out_n,
	output logic batfail_flag,
	output logic debug_active,
	output sdwc_pkg::sdwc_state_t mode_state
);
	import sdwc_pkg::*;

	// Asynchronous pins pass two flops before use
	logic [1:0] reg_low_sq, wake_sq;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_low_sq <= 2'h0;
			wake_sq <= 2'h0;
		end else begin
			reg_low_sq <= {reg_low_sq[0], main_regulator_low};
			wake_sq <= {wake_sq[0], wake_event};
		end
	end
	logic reg_low, wake_s;
	assign reg_low = reg_low_sq[1];
	assign wake_s = wake_sq[1];

	// Command decode helpers
	function automatic logic is_mcr(input logic [7:0] b);
		return b[7:4] == `SDWC_MCR_HI;
	endfunction
	function automatic logic is_ndbg(input logic [7:0] b);
		return (b & `SDWC_CMD_MASK) == `SDWC_CMD_NDBG;
	endfunction

	logic mcr_wr, tim_wr;
	assign mcr_wr = spi_wr_stb && is_mcr(spi_wr_byte);
	assign tim_wr = wd_clear_stb;

	sdwc_state_t state_q, state_d;
	logic [31:0] cnt_q, cnt_d;
	logic [31:0] wd_q, wd_d;
	logic batfail_q, batfail_d;
	logic armed_q, armed_d;
	logic dbg_q, dbg_d;
	logic seq_q, seq_d;
	logic wdf_n_q, wdf_n_d;
	logic rst_n_q, rst_n_d;
	logic wd_fault;
	logic wd_open;

	// Windowed watchdog: first half closed, second half open
	assign wd_open = !window_mode || (wd_q >= (WD_CYC / 2));

	// Next-state computation of the mode sequencer
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q + 32'h1;
		wd_d = wd_q + 32'h1;
		batfail_d = batfail_q;
		armed_d = armed_q;
		dbg_d = dbg_q;
		seq_d = seq_q;
		wdf_n_d = wdf_n_q;
		rst_n_d = rst_n_q;
		wd_fault = 1'b0;
		if (batfail_clear_stb)
			batfail_d = 1'b0;
		case (state_q)
			SDWC_RESET: begin
				rst_n_d = 1'b0;
				if (cnt_q >= RST_CYC - 1) begin
					state_d = SDWC_NREQ;
					cnt_d = 32'h0;
					rst_n_d = 1'b1;
				end
			end
			SDWC_NREQ: begin
				if (tim_wr) begin
					state_d = SDWC_NORMAL;
					wd_d = 32'h0;
					wdf_n_d = 1'b1;
					seq_d = !dbg_q;
				end else if (dbg_q && mcr_wr && is_ndbg(spi_wr_byte)) begin
					state_d = SDWC_DEBUG;
				end else if (dbg_q && mcr_wr && spi_wr_byte[3:0] == `SDWC_MODE_STANDBY) begin
					// Standby debug is held in the debug state, like normal debug
					state_d = SDWC_DEBUG;
				end else if (cnt_q >= NREQ_CYC - 1) begin
					state_d = SDWC_RESET;
					cnt_d = 32'h0;
					rst_n_d = 1'b0;
					armed_d = 1'b0;
					seq_d = 1'b0;
				end
			end
			SDWC_NORMAL, SDWC_STANDBY: begin
				if (seq_q && cnt_q >= NREQ_CYC - 1)
					seq_d = 1'b0;
				if (mcr_wr) begin
					if (spi_wr_byte == `SDWC_CMD_ARM && batfail_q && seq_q && !armed_q)
						armed_d = 1'b1;
					else if (armed_q && is_ndbg(spi_wr_byte)) begin
						state_d = SDWC_DEBUG;
						dbg_d = 1'b1;
						seq_d = 1'b0;
					end else begin
						seq_d = 1'b0;
						armed_d = 1'b0;
						if (spi_wr_byte[3:0] == `SDWC_MODE_STOP && stop_watchdog_enable == 1'b0)
							state_d = SDWC_STOP;
						else if (spi_wr_byte[3:0] == `SDWC_MODE_STOP)
							state_d = SDWC_STOP;
						else if (spi_wr_byte[3:0] == `SDWC_MODE_SLEEP)
							state_d = SDWC_SLEEP;
						else if (spi_wr_byte[3:0] == `SDWC_MODE_STANDBY)
							state_d = SDWC_STANDBY;
					end
				end
				if (tim_wr) begin
					seq_d = seq_q;
					if (!wd_open)
						wd_fault = 1'b1;
					else begin
						wd_d = 32'h0;
						wdf_n_d = 1'b1;
					end
				end else if (wd_q >= WD_CYC - 1)
					wd_fault = 1'b1;
			end
			SDWC_STOP: begin
				if (wake_s) begin
					state_d = SDWC_NORMAL;
					wd_d = 32'h0;
				end else if (stop_watchdog_enable && (wd_q >= WD_CYC - 1 || tim_wr))
					wd_fault = 1'b1;
			end
			SDWC_SLEEP: begin
				if (wake_s) begin
					state_d = SDWC_RESET;
					cnt_d = 32'h0;
					rst_n_d = 1'b0;
				end
			end
			default: begin
				if (mcr_wr && spi_wr_byte[3:0] == `SDWC_DATA_EXIT) begin
					dbg_d = 1'b0;
					armed_d = 1'b0;
					state_d = SDWC_NORMAL;
					wd_d = 32'h0;
				end else if (mcr_wr && spi_wr_byte[3:0] == `SDWC_MODE_STANDBY)
					state_d = SDWC_DEBUG;
				else if (mcr_wr && spi_wr_byte[3:0] == `SDWC_MODE_STOP)
					state_d = SDWC_STOP;
				else if (mcr_wr && spi_wr_byte[3:0] == `SDWC_MODE_SLEEP)
					state_d = SDWC_SLEEP;
			end
		endcase
		if (dbg_q && wake_s && (state_q == SDWC_STOP || state_q == SDWC_SLEEP)) begin
			state_d = SDWC_NREQ;
			cnt_d = 32'h0;
			rst_n_d = 1'b1;
		end
		if (dbg_q)
			wd_fault = 1'b0;
		if (wd_fault) begin
			state_d = SDWC_RESET;
			cnt_d = 32'h0;
			rst_n_d = 1'b0;
			wdf_n_d = 1'b0;
			armed_d = 1'b0;
		end
		if (reg_low && state_q != SDWC_RESET) begin
			state_d = SDWC_RESET;
			cnt_d = 32'h0;
			rst_n_d = 1'b0;
			armed_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= SDWC_NREQ;
			cnt_q <= 32'h0;
			wd_q <= 32'h0;
			batfail_q <= 1'b1;
			armed_q <= 1'b0;
			dbg_q <= 1'b0;
			seq_q <= 1'b0;
			wdf_n_q <= 1'b1;
			rst_n_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			wd_q <= wd_d;
			batfail_q <= batfail_d;
			armed_q <= armed_d;
			dbg_q <= dbg_d;
			seq_q <= seq_d;
			wdf_n_q <= wdf_n_d;
			rst_n_q <= rst_n_d;
		end
	end

	assign rst_out_n = rst_n_q;
	assign watchdog_fault_out_n = wdf_n_q;
	assign batfail_flag = batfail_q;
	assign debug_active = dbg_q;
	assign mode_state = state_q;

	a_nreq_window: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == SDWC_NREQ && cnt_q >= NREQ_CYC - 1 && !tim_wr && !dbg_q)
		|=> state_q == SDWC_RESET) else $error("request window not ended");
	a_reset_pin_low: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == SDWC_RESET && cnt_q > 0) |-> !rst_out_n)
		else $error("reset pin high in reset");
	a_debug_no_fault: assert property (@(posedge clk_sys) disable iff (rst)
		(dbg_q && $stable(dbg_q) && !reg_low)
		|=> $stable(watchdog_fault_out_n) || watchdog_fault_out_n)
		else $error("fault in debug");
	a_tim_leaves_nreq: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == SDWC_NREQ && tim_wr && !reg_low) |=> state_q == SDWC_NORMAL)
		else $error("timing write ignored");
	a_regulator_reset: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_low && state_q != SDWC_RESET) |=> state_q == SDWC_RESET)
		else $error("regulator low not reset");
	a_debug_exit: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == SDWC_DEBUG && mcr_wr && spi_wr_byte[3:0] == `SDWC_DATA_EXIT && !reg_low)
		|=> !debug_active) else $error("debug not left");
	a_fault_held: assert property (@(posedge clk_sys) disable iff (rst)
		(!watchdog_fault_out_n && !tim_wr) |=> !watchdog_fault_out_n)
		else $error("fault released early");
	a_closed_clear: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == SDWC_NORMAL && !dbg_q && tim_wr && !wd_open) |=> state_q == SDWC_RESET)
		else $error("closed clear accepted");

	// armed select enters debug
	// A timeout or regulator reset in the same cycle wins over the entry
	sequence s_debug_select;
		(state_q == SDWC_NORMAL || state_q == SDWC_STANDBY) && armed_q && mcr_wr
			&& is_ndbg(spi_wr_byte) && !reg_low && !wd_fault;
	endsequence
	sequence s_debug_on;
		state_q == SDWC_DEBUG && dbg_q;
	endsequence
	a_debug_entry: assert property (@(posedge clk_sys) disable iff (rst)
		s_debug_select |=> s_debug_on)
		else $error("debug select ignored");

	a_debug_wake: assert property (@(posedge clk_sys) disable iff (rst)
		(dbg_q && wake_s && !reg_low && (state_q == SDWC_STOP || state_q == SDWC_SLEEP))
		|=> (state_q == SDWC_NREQ && cnt_q == 32'h0 && rst_out_n))
		else $error("debug wake missed request window");

	a_stop_quiet: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == SDWC_STOP && dbg_q && !wake_s && !reg_low) |=> state_q == SDWC_STOP)
		else $error("debug stop left without wake");

	a_reset_release: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == SDWC_RESET && cnt_q >= RST_CYC - 1) |=> (state_q == SDWC_NREQ && rst_out_n))
		else $error("reset pulse not released");

	a_seq_timeout: assert property (@(posedge clk_sys) disable iff (rst)
		(seq_q && !tim_wr && cnt_q >= NREQ_CYC - 1
			&& (state_q == SDWC_NORMAL || state_q == SDWC_STANDBY)) |=> !seq_q)
		else $error("arming window left open");

	a_batfail_hold: assert property (@(posedge clk_sys) disable iff (rst)
		(batfail_flag && !batfail_clear_stb) |=> batfail_flag)
		else $error("battery flag lost");
endmodule // sdwc_top

// File: testbench/sdwc_host.sv
// Host controller model issuing watchdog and mode writes
`timescale 1ns/1ns
module sdwc_host (
	input wire logic clk_sys,
	output logic spi_wr_stb,
	output logic [7:0] spi_wr_byte,
	output logic wd_clear_stb
);
	// Idle strobes from time zero
	initial begin
		spi_wr_stb = 1'b0;
		spi_wr_byte = 8'h00;
		wd_clear_stb = 1'b0;
	end
	task automatic mode_control_reg(input logic [7:0] b);
		@(negedge clk_sys);
		spi_wr_byte = b;
		spi_wr_stb = 1'b1;
		@(negedge clk_sys);
		spi_wr_stb = 1'b0;
		spi_wr_byte = ~b; // Stale byte must never count
	endtask
	task automatic tim();
		@(negedge clk_sys);
		wd_clear_stb = 1'b1;
		@(negedge clk_sys);
		wd_clear_stb = 1'b0;
	endtask
endmodule // sdwc_host

// File: testbench/sdwc_top_bench.sv
// Self-checking bench for the debug watchdog control block
`timescale 1ns/1ns
module sdwc_top_bench;
	import sdwc_pkg::*;
	localparam int NR = 200;
	localparam int RC = 50;
	localparam int WD = 400;
	// Driven from the main process so that no input is a fixed tie
	logic clk_sys, rst, wdm, swe, reg_low, wake, bclr;
	logic stb, clr, rst_n, fault_n, bf, dbg;
	logic [7:0] byt;
	sdwc_state_t ms;
	int num_errors = 0;
	int check_count = 0;
	// Short counts keep the run brief
	sdwc_top #(.NREQ_CYC(NR), .RST_CYC(RC), .WD_CYC(WD)) sdwc_top_inst (
		.clk_sys(clk_sys), .rst(rst), .spi_wr_stb(stb), .spi_wr_byte(byt),
		.wd_clear_stb(clr), .window_mode(wdm), .stop_watchdog_enable(swe),
		.main_regulator_low(reg_low), .wake_event(wake), .batfail_clear_stb(bclr),
		.rst_out_n(rst_n), .watchdog_fault_out_n(fault_n), .batfail_flag(bf),
		.debug_active(dbg), .mode_state(ms));
	sdwc_host sdwc_host_inst (.clk_sys(clk_sys), .spi_wr_stb(stb),
		.spi_wr_byte(byt), .wd_clear_stb(clr));
	// 100 MHz clock
	always #5 clk_sys = ~clk_sys;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Bounded wait for a mode; running out ends the run
	task automatic wait_ms(input sdwc_state_t s, input int n);
		for (int i = 0; i < n && ms !== s; i++)
			cyc(1);
		chk(8'(ms), 8'(s));
		if (ms !== s)
			results();
	endtask
	task automatic t_unconf();
		int lo;
		lo = 0;
		chk({bf, ms}, {1'b1, SDWC_NREQ});
		wait_ms(SDWC_RESET, NR + 5);
		while (rst_n === 1'b0 && lo < RC + 5) begin
			lo++;
			cyc(1);
		end
		chk(8'(lo > RC - 2 && lo < RC + 2), 8'h01);
		chk(8'(ms), 8'(SDWC_NREQ));
	endtask
	task automatic t_debug();
		sdwc_host_inst.tim();
		wait_ms(SDWC_NORMAL, 4);
		sdwc_host_inst.mode_control_reg(8'h10);
		sdwc_host_inst.mode_control_reg(8'h1d);
		wait_ms(SDWC_DEBUG, 4);
		cyc(WD * 2);
		chk(8'({rst_n, dbg}), 8'h03);
		sdwc_host_inst.mode_control_reg(8'h10);
		wait_ms(SDWC_NORMAL, 4);
		chk(8'(dbg), 8'h00);
	endtask
	task automatic t_timeout();
		wait_ms(SDWC_RESET, WD * 2 + 10);
		chk(8'({rst_n, fault_n}), 8'h00);
		wait_ms(SDWC_NREQ, RC + 5);
		chk(8'(fault_n), 8'h00);
		sdwc_host_inst.tim();
		wait_ms(SDWC_NORMAL, 4);
		chk(8'(fault_n), 8'h01);
	endtask
	task automatic t_window();
		wdm = 1'b1;
		sdwc_host_inst.tim();
		wait_ms(SDWC_RESET, 5);
		wdm = 1'b0;
		wait_ms(SDWC_NREQ, RC + 5);
		sdwc_host_inst.tim();
		wait_ms(SDWC_NORMAL, 4);
		// A clear late in the period lands in the open half
		wdm = 1'b1;
		cyc(WD / 2 + 10);
		sdwc_host_inst.tim();
		cyc(2);
		chk(8'({ms == SDWC_NORMAL, fault_n}), 8'h03);
		wdm = 1'b0;
		// Request time is long over, so arming must be refused
		sdwc_host_inst.mode_control_reg(8'h10);
		sdwc_host_inst.mode_control_reg(8'h15);
		cyc(2);
		chk(8'(dbg), 8'h00);
		wait_ms(SDWC_RESET, WD + 10);
		wait_ms(SDWC_NREQ, RC + 5);
	endtask
	task automatic t_stop();
		sdwc_host_inst.tim();
		sdwc_host_inst.mode_control_reg(8'h10);
		sdwc_host_inst.mode_control_reg(8'h15);
		wait_ms(SDWC_DEBUG, 4);
		swe = 1'b1;
		sdwc_host_inst.mode_control_reg(8'h12);
		wait_ms(SDWC_STOP, 4);
		cyc(WD * 2);
		chk(8'({rst_n, ms == SDWC_STOP}), 8'h03);
		wake = 1'b1;
		wait_ms(SDWC_NREQ, 6);
		wake = 1'b0;
		swe = 1'b0;
		sdwc_host_inst.mode_control_reg(8'h15);
		wait_ms(SDWC_DEBUG, 4);
		// Sleep from debug also wakes into the request window
		sdwc_host_inst.mode_control_reg(8'h13);
		wait_ms(SDWC_SLEEP, 4);
		wake = 1'b1;
		wait_ms(SDWC_NREQ, 6);
		wake = 1'b0;
		chk(8'({rst_n, dbg}), 8'h03);
		sdwc_host_inst.mode_control_reg(8'h15);
		wait_ms(SDWC_DEBUG, 4);
		reg_low = 1'b1;
		wait_ms(SDWC_RESET, 6);
		reg_low = 1'b0;
		wait_ms(SDWC_NREQ, RC + 5);
	endtask
	task automatic t_nodbg();
		// Debug survives a regulator reset, so a fresh power-up starts this one
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		chk({bf, ms}, {1'b1, SDWC_NREQ});
		chk(8'({rst_n, fault_n, dbg}), 8'h06);
		bclr = 1'b1;
		cyc(1);
		bclr = 1'b0;
		cyc(1);
		chk(8'(bf), 8'h00);
		sdwc_host_inst.tim();
		sdwc_host_inst.mode_control_reg(8'h10);
		sdwc_host_inst.mode_control_reg(8'h15);
		cyc(3);
		chk(8'({ms == SDWC_NORMAL, dbg}), 8'h02);
	endtask
	// Reset for 20 cycles, then the scenarios in order
	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		wdm = 1'b0;
		swe = 1'b0;
		reg_low = 1'b0;
		wake = 1'b0;
		bclr = 1'b0;
		cyc(20);
		rst = 1'b0;
		t_unconf();
		t_debug();
		t_timeout();
		t_window();
		t_stop();
		t_nodbg();
		results();
	end
endmodule // sdwc_top_bench
